// ---- rtl/mad_pkg.sv ----
// constants, types and register map for the mmio address decoder
package mad_pkg;
   // ------------------------------------------------------------
   // register byte offsets on the control bus
   // ------------------------------------------------------------
   localparam logic [4:0] OFS_CONFIG = 5'h00;
   localparam logic [4:0] OFS_AFC    = 5'h04;
   localparam logic [4:0] OFS_MISC   = 5'h08;
   localparam logic [4:0] OFS_SEQ    = 5'h0c;
   localparam logic [4:0] OFS_WBASE  = 5'h10;
   localparam logic [4:0] OFS_STATUS = 5'h14;
   // ------------------------------------------------------------
   // field positions and reset values
   // ------------------------------------------------------------
   localparam int CFG_SCHEME_HI = 4;
   localparam int CFG_SCHEME_LO = 3;
   localparam int AFC_LEGACY_BIT = 5;
   localparam int MISC_WIDE_BIT = 9;
   localparam int SEQ_MEM_ONLY_BIT = 7;
   localparam int WBASE_HI = 7;
   localparam int WBASE_LO = 2;
   localparam logic [1:0] SCHEME_LEGACY = 2'h2;
   localparam logic [1:0] SCHEME_NEW = 2'h3;
   localparam logic [1:0] RST_SCHEME_PCI = 2'h3;
   localparam logic [1:0] RST_SCHEME_VL = 2'h0;
   localparam logic [5:0] RST_WBASE = 6'h00;
   localparam logic [1:0] STRAP_LOAD_CNT = 2'h2;
   localparam logic [1:0] STRAP_DONE_CNT = 2'h3;
   // ------------------------------------------------------------
   // legacy low-memory ranges and window offsets
   // ------------------------------------------------------------
   localparam logic [31:0] LEG_PIX_LO = 32'h000a0000;
   localparam logic [31:0] LEG_PIX_HI = 32'h000a7fff;
   localparam logic [31:0] LEG_CMD_LO = 32'h000a8000;
   localparam logic [31:0] LEG_CMD_HI = 32'h000affff;
   localparam logic [7:0] PORT_SEL = 8'hba;
   localparam int HALF_BIT = 25;
   localparam logic [24:0] LIN_HI = 25'h0ffffff;
   localparam logic [24:0] IMG_LO = 25'h1000000;
   localparam logic [24:0] IMG_HI = 25'h1007fff;
   localparam logic [24:0] PCI_LO = 25'h1008000;
   localparam logic [24:0] PCI_HI = 25'h100803f;
   localparam logic [24:0] PACK_LO = 25'h1008100;
   localparam logic [24:0] PACK_HI = 25'h100816f;
   localparam logic [24:0] CURY_LO = 25'h10082e8;
   localparam logic [24:0] CURY_HI = 25'h10082eb;
   localparam logic [24:0] SYS_SETUP = 25'h1008502;
   localparam logic [24:0] SYS_STAT = 25'h1008504;
   localparam logic [24:0] SYS_VSE = 25'h1008508;
   localparam logic [24:0] SYS_AFC = 25'h100850c;
   localparam logic [24:0] ENH_LO = 25'h10086e8;
   localparam logic [24:0] ENH_HI = 25'h100eeea;
   localparam logic [24:0] PFD_LO = 25'h1010000;
   localparam logic [24:0] PFD_HI = 25'h1013fff;
   localparam logic [24:0] PFM_LO = 25'h1014000;
   localparam logic [24:0] PFM_HI = 25'h1017fff;
   localparam logic [24:0] PFR_LO = 25'h1018080;
   localparam logic [24:0] PFR_HI = 25'h101809f;
   // ------------------------------------------------------------
   // types
   // ------------------------------------------------------------
   typedef enum logic [3:0] {
      RGN_NONE, RGN_PIXEL_IO, RGN_LEG_CMD, RGN_LINEAR, RGN_IMAGE,
      RGN_PCI_CFG, RGN_PACKED, RGN_CURRENT_Y_POSITION, RGN_SYS_REG, RGN_ENH_REG,
      RGN_PF_DATA, RGN_PF_MASK, RGN_PF_REG, RGN_IO_PORT
   } mad_region_t;
   typedef struct packed {
      logic        mem;
      logic        write;
      logic        wide;
      logic [31:0] addr;
   } mad_cycle_t;
   typedef struct packed {
      logic        hit;
      logic        refused;
      logic        read_zero;
      logic        big_endian;
      logic        packed_pair;
      logic        io_equiv;
      mad_region_t region;
      logic [25:0] offset;
   } mad_decode_t;
endpackage

// ---- rtl/mad_decoder.sv ----
// host memory cycle decoder with its control registers
// What this block does and what the host must do
// RULE_01: scheme field value 10 enables the legacy memory map.
// RULE_02: with scheme bit 3 clear, legacy enable bit also enables it.
// RULE_03: legacy A0000-A7FFF accesses go to pixel transfer as I/O writes.
// RULE_04: host uses even word or doubleword pixel addresses per bus width.
// RULE_05: host keeps legacy pixel writes inside the 32 KB range.
// RULE_06: legacy A8000-AFFFF decodes engine registers at their port address.
// RULE_07: legacy 16-bit reads/writes; 32-bit only writes with wide bit set.
// RULE_08: new map is a 64 MB window, low half little, high half big.
// RULE_09: scheme field value 11 enables the new memory map.
// RULE_10: scheme resets to 11 on PCI strap, 00 otherwise.
// RULE_11: access select bit picks I/O plus memory or memory only.
// RULE_12: little half holds linear, image transfer and PCI config.
// RULE_13: setup, status, video enable, function control at fixed offsets.
// RULE_14: current Y registers and engine registers at port addresses.
// RULE_15: pixel formatter data, mask and register ranges.
// RULE_16: big half repeats the layout offset by 200 0000.
// RULE_17: window base bits come from base register or PCI BAR0.
// RULE_18: host programs a nonzero window base.
// RULE_19: new map: 16-bit reads/writes, 32-bit writes only.
// RULE_20: packed register pairs enabled whenever the new map is on.
// RULE_21: window misses are ignored and read as zero.
`timescale 1ns/1ps
module mad_decoder
(
   input  wire logic                clk,
   input  wire logic                nrst,
   input  wire logic [4:0]          av_address,
   input  wire logic                av_read,
   input  wire logic                av_write,
   input  wire logic [31:0]         av_writedata,
   input  wire logic [3:0]          av_byteenable,
   output      logic [31:0]         av_readdata,
   output      logic                av_waitrequest,
   input  wire logic                pci_strap_pin,
   input  wire logic [5:0]          pci_bar0_hi,
   input  wire logic                hc_valid,
   input  wire mad_pkg::mad_cycle_t hc_cycle,
   output      logic                dec_valid,
   output      mad_pkg::mad_decode_t dec_result,
   output      logic                legacy_enabled,
   output      logic                new_enabled,
   output      logic                io_access_allowed
);
   // ------------------------------------------------------------
   // reset and strap synchronisers
   // ------------------------------------------------------------
   logic       rst_meta_reg;
   logic       rst_n_reg;
   logic       strap_meta_reg;
   logic       strap_sync_reg;
   logic [1:0] strap_cnt_reg;
   logic       pci_sel_reg;

   // reset release through two flops
   always_ff @(posedge clk or negedge nrst)
      if (!nrst)
      begin
         rst_meta_reg <= 1'b0;
         rst_n_reg    <= 1'b0;
      end
      else
      begin
         rst_meta_reg <= 1'b1;
         rst_n_reg    <= rst_meta_reg;
      end

   // strap pin settles two flops before it is used
   always_ff @(posedge clk or negedge rst_n_reg)
      if (!rst_n_reg)
      begin
         strap_meta_reg <= 1'b0;
         strap_sync_reg <= 1'b0;
         strap_cnt_reg  <= 2'h0;
         pci_sel_reg    <= 1'b0;
      end
      else
      begin
         strap_meta_reg <= pci_strap_pin;
         strap_sync_reg <= strap_meta_reg;
         if (strap_cnt_reg != mad_pkg::STRAP_DONE_CNT)
            strap_cnt_reg <= strap_cnt_reg + 2'h1;
         if (strap_cnt_reg == mad_pkg::STRAP_LOAD_CNT)
            pci_sel_reg <= strap_sync_reg;
      end

   // ------------------------------------------------------------
   // control bus slave
   // ------------------------------------------------------------
   logic [1:0]  scheme_reg;
   logic        afc_legacy_reg;
   logic        misc_wide_reg;
   logic        mem_only_reg;
   logic [5:0]  wbase_reg;
   logic [31:0] rdata_next;
   logic        av_waitrequest_reg;
   logic [31:0] av_readdata_reg;
   logic        legacy_en;
   logic        new_en;
   logic        io_allow;

   wire av_req  = av_read | av_write;
   wire av_take = av_req & ~av_waitrequest_reg;
   wire wr_b0   = av_take & av_write & av_byteenable[0];
   wire wr_b1   = av_take & av_write & av_byteenable[1];
   wire strap_load = strap_cnt_reg == mad_pkg::STRAP_LOAD_CNT;

   // read mux, unmapped offsets read zero
   always_comb
   begin
      rdata_next = 32'h00000000;
      case (av_address)
         mad_pkg::OFS_CONFIG:
            rdata_next[mad_pkg::CFG_SCHEME_HI:mad_pkg::CFG_SCHEME_LO] =
               scheme_reg;
         mad_pkg::OFS_AFC:
            rdata_next[mad_pkg::AFC_LEGACY_BIT] = afc_legacy_reg;
         mad_pkg::OFS_MISC:
            rdata_next[mad_pkg::MISC_WIDE_BIT] = misc_wide_reg;
         mad_pkg::OFS_SEQ:
            rdata_next[mad_pkg::SEQ_MEM_ONLY_BIT] = mem_only_reg;
         mad_pkg::OFS_WBASE:
            rdata_next[mad_pkg::WBASE_HI:mad_pkg::WBASE_LO] = wbase_reg;
         mad_pkg::OFS_STATUS:
            rdata_next = {24'h000000, pci_sel_reg, io_allow,
                          new_en, legacy_en, dec_result.region};
         default:
            rdata_next = 32'h00000000;
      endcase
   end

   // one wait cycle, then the request is taken on the low edge
   always_ff @(posedge clk or negedge rst_n_reg)
      if (!rst_n_reg)
      begin
         av_waitrequest_reg <= 1'b1;
         av_readdata_reg    <= 32'h00000000;
      end
      else
      begin
         av_waitrequest_reg <= ~(av_req & av_waitrequest_reg);
         if (av_req & av_waitrequest_reg)
            av_readdata_reg <= rdata_next;
      end

   // strap load wins over a software write in the same cycle
   always_ff @(posedge clk or negedge rst_n_reg)
      if (!rst_n_reg)
         scheme_reg <= mad_pkg::RST_SCHEME_VL;
      else if (strap_load)
         scheme_reg <= strap_sync_reg ? mad_pkg::RST_SCHEME_PCI
                                      : mad_pkg::RST_SCHEME_VL; // RULE_10
      else if (wr_b0 && av_address == mad_pkg::OFS_CONFIG)
         scheme_reg <= av_writedata[mad_pkg::CFG_SCHEME_HI:
                                    mad_pkg::CFG_SCHEME_LO];

   // plain control bits
   always_ff @(posedge clk or negedge rst_n_reg)
      if (!rst_n_reg)
      begin
         afc_legacy_reg <= 1'b0;
         misc_wide_reg  <= 1'b0;
         mem_only_reg   <= 1'b0;
         wbase_reg      <= mad_pkg::RST_WBASE;
      end
      else
      begin
         if (wr_b0 && av_address == mad_pkg::OFS_AFC)
            afc_legacy_reg <= av_writedata[mad_pkg::AFC_LEGACY_BIT];
         if (wr_b1 && av_address == mad_pkg::OFS_MISC)
            misc_wide_reg <= av_writedata[mad_pkg::MISC_WIDE_BIT];
         if (wr_b0 && av_address == mad_pkg::OFS_SEQ)
            mem_only_reg <= av_writedata[mad_pkg::SEQ_MEM_ONLY_BIT];
         if (wr_b0 && av_address == mad_pkg::OFS_WBASE)
            wbase_reg <= av_writedata[mad_pkg::WBASE_HI:mad_pkg::WBASE_LO];
      end

   // ------------------------------------------------------------
   // scheme enables
   // ------------------------------------------------------------
   assign legacy_en = scheme_reg == mad_pkg::SCHEME_LEGACY // RULE_01
                    | (~scheme_reg[0] & afc_legacy_reg); // RULE_02
   assign new_en    = scheme_reg == mad_pkg::SCHEME_NEW; // RULE_09
   wire   mmio_any  = legacy_en | new_en;
   assign io_allow  = ~(mmio_any & mem_only_reg); // RULE_11

   // ------------------------------------------------------------
   // address decode
   // ------------------------------------------------------------
   wire [31:0] a    = hc_cycle.addr;
   wire [24:0] lo   = a[24:0];
   wire        mem  = hc_cycle.mem;
   wire        port = a[9:2] == mad_pkg::PORT_SEL;
   // base source follows the bus strap caught after reset
   wire [5:0]  base = pci_sel_reg ? pci_bar0_hi : wbase_reg; // RULE_17

   // legacy decode sits ahead of the window so a zero base cannot steal it
   wire leg_pix = legacy_en & mem & a >= mad_pkg::LEG_PIX_LO
                & a <= mad_pkg::LEG_PIX_HI; // RULE_03
   wire leg_cmd = legacy_en & mem & a >= mad_pkg::LEG_CMD_LO
                & a <= mad_pkg::LEG_CMD_HI & port; // RULE_06
   wire win     = new_en & mem & a[31:26] == base; // RULE_08

   // per-region compares on the offset inside one half
   wire r_lin  = lo <= mad_pkg::LIN_HI; // RULE_12
   wire r_img  = lo >= mad_pkg::IMG_LO & lo <= mad_pkg::IMG_HI;
   wire r_pci  = lo >= mad_pkg::PCI_LO & lo <= mad_pkg::PCI_HI;
   wire r_pack = lo >= mad_pkg::PACK_LO & lo <= mad_pkg::PACK_HI;
   wire r_cury = lo >= mad_pkg::CURY_LO & lo <= mad_pkg::CURY_HI; // RULE_14
   wire r_sys  = lo[24:1] == mad_pkg::SYS_SETUP[24:1]
               | lo[24:1] == mad_pkg::SYS_STAT[24:1]
               | lo[24:1] == mad_pkg::SYS_VSE[24:1]
               | lo[24:1] == mad_pkg::SYS_AFC[24:1]; // RULE_13
   wire r_enh  = lo >= mad_pkg::ENH_LO & lo <= mad_pkg::ENH_HI & port;
   wire r_pfd  = lo >= mad_pkg::PFD_LO & lo <= mad_pkg::PFD_HI; // RULE_15
   wire r_pfm  = lo >= mad_pkg::PFM_LO & lo <= mad_pkg::PFM_HI;
   wire r_pfr  = lo >= mad_pkg::PFR_LO & lo <= mad_pkg::PFR_HI;

   // both halves share the compares; bit 25 only picks endianness
   mad_pkg::mad_region_t win_rgn;
   assign win_rgn = r_lin  ? mad_pkg::RGN_LINEAR  : // RULE_16
                    r_img  ? mad_pkg::RGN_IMAGE   :
                    r_pci  ? mad_pkg::RGN_PCI_CFG :
                    r_pack ? mad_pkg::RGN_PACKED  :
                    r_cury ? mad_pkg::RGN_CURRENT_Y_POSITION   :
                    r_sys  ? mad_pkg::RGN_SYS_REG :
                    r_enh  ? mad_pkg::RGN_ENH_REG :
                    r_pfd  ? mad_pkg::RGN_PF_DATA :
                    r_pfm  ? mad_pkg::RGN_PF_MASK :
                    r_pfr  ? mad_pkg::RGN_PF_REG  : mad_pkg::RGN_NONE;

   mad_pkg::mad_region_t rgn;
   assign rgn = ~mem    ? mad_pkg::RGN_IO_PORT  :
                leg_pix ? mad_pkg::RGN_PIXEL_IO :
                leg_cmd ? mad_pkg::RGN_LEG_CMD  :
                win     ? win_rgn : mad_pkg::RGN_NONE;

   wire matched = rgn != mad_pkg::RGN_NONE
                & (mem | io_allow); // RULE_11
   // no 32-bit reads in the window or legacy command range; legacy command wide writes need the misc bit
   wire wide_bad = hc_cycle.wide & (leg_cmd | win)
                 & (~hc_cycle.write // RULE_19
                 | leg_cmd & ~misc_wide_reg); // RULE_07

   mad_pkg::mad_decode_t dec_next;
   assign dec_next.hit         = matched & ~wide_bad;
   assign dec_next.refused     = matched & wide_bad;
   assign dec_next.read_zero   = win & ~matched & ~hc_cycle.write; // RULE_21
   assign dec_next.big_endian  = win & a[mad_pkg::HALF_BIT];
   assign dec_next.packed_pair = new_en & rgn == mad_pkg::RGN_PACKED; // RULE_20
   assign dec_next.io_equiv    = leg_pix | win & r_img & ~r_lin;
   assign dec_next.region      = rgn;
   assign dec_next.offset      = a[25:0];

   // ------------------------------------------------------------
   // registered outputs
   // ------------------------------------------------------------
   logic                 dec_valid_reg;
   mad_pkg::mad_decode_t dec_result_reg;
   logic                 legacy_en_reg;
   logic                 new_en_reg;
   logic                 io_allow_reg;

   // decode result lands one edge after the cycle is offered
   always_ff @(posedge clk or negedge rst_n_reg)
      if (!rst_n_reg)
      begin
         dec_valid_reg  <= 1'b0;
         dec_result_reg <= '0;
         legacy_en_reg  <= 1'b0;
         new_en_reg     <= 1'b0;
         io_allow_reg   <= 1'b1;
      end
      else
      begin
         dec_valid_reg  <= hc_valid;
         dec_result_reg <= hc_valid ? dec_next : '0;
         legacy_en_reg  <= legacy_en;
         new_en_reg     <= new_en;
         io_allow_reg   <= io_allow;
      end

   assign av_waitrequest    = av_waitrequest_reg;
   assign av_readdata       = av_readdata_reg;
   assign dec_valid         = dec_valid_reg;
   assign dec_result        = dec_result_reg;
   assign legacy_enabled    = legacy_en_reg;
   assign new_enabled       = new_en_reg;
   assign io_access_allowed = io_allow_reg;

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n_reg);

   legacy_on_a: assert property // RULE_01
      (scheme_reg == mad_pkg::SCHEME_LEGACY |=> legacy_enabled)
      else $error("legacy scheme value did not enable legacy map");
   afc_legacy_a: assert property // RULE_02
      (!scheme_reg[0] && afc_legacy_reg |=> legacy_enabled)
      else $error("function control bit did not enable legacy map");
   new_on_a: assert property // RULE_09
      (new_enabled == $past(scheme_reg == mad_pkg::SCHEME_NEW))
      else $error("new map enable does not follow scheme field");
   strap_load_a: assert property // RULE_10
      (strap_load |=> scheme_reg == (pci_sel_reg ? mad_pkg::RST_SCHEME_PCI
                                                  : mad_pkg::RST_SCHEME_VL))
      else $error("scheme field not loaded from strap");
   pix_route_a: assert property // RULE_03
      (hc_valid && leg_pix |=> dec_result.region == mad_pkg::RGN_PIXEL_IO
                           && dec_result.io_equiv && dec_result.hit)
      else $error("legacy pixel access not routed as port write");
   cmd_wide_a: assert property // RULE_07
      (hc_valid && leg_cmd && hc_cycle.wide
       && (!hc_cycle.write || !misc_wide_reg)
       |=> dec_result.refused && !dec_result.hit)
      else $error("illegal legacy wide access accepted");
   io_block_a: assert property // RULE_11
      (hc_valid && !hc_cycle.mem |=> dec_result.hit == $past(io_allow))
      else $error("port access gating wrong");
   half_endian_a: assert property // RULE_16
      (hc_valid && win |=> dec_result.big_endian == $past(a[25])
                        && dec_result.offset == $past(a[25:0]))
      else $error("window half or offset wrong");
   base_sel_a: assert property // RULE_17
      (hc_valid && new_en && mem && a[31:26] != base |=> !dec_result.hit)
      else $error("cycle outside window base accepted");
   wide_read_a: assert property // RULE_19
      (hc_valid && win && hc_cycle.wide && !hc_cycle.write
       |=> !dec_result.hit ##1 1'b1)
      else $error("wide read in new map accepted");
   miss_zero_a: assert property // RULE_21
      (hc_valid && win && win_rgn == mad_pkg::RGN_NONE
       |=> !dec_result.hit && !dec_result.refused
        && dec_result.read_zero == !$past(hc_cycle.write))
      else $error("window miss not ignored");
   bus_answer_a: assert property
      (av_req && av_waitrequest |=> !av_waitrequest ##1 av_waitrequest)
      else $error("bus answer not one cycle late");
endmodule // mad_decoder

// ---- sim/mad_host_model.sv ----
// host cpu model that offers memory and port cycles to the decoder
`timescale 1ns/1ps
module mad_host_model
(
   input  wire logic                clk,
   output      logic                hc_valid,
   output      mad_pkg::mad_cycle_t hc_cycle
);
   // ------------------------------------------------------------
   // idle bus and one-cycle offer
   // ------------------------------------------------------------
   initial
   begin
      hc_valid = 1'b0;
      hc_cycle = '0;
   end
   // bit 0 cleared so word and doubleword cycles stay even
   task automatic offer(input mad_pkg::mad_cycle_t c);
      hc_cycle <= {c[34:1], 1'b0};
      hc_valid <= 1'b1;
      @(posedge clk);
      hc_valid <= 1'b0;
      // released bus shows the inverse so a stale cycle never looks live
      hc_cycle <= ~c;
   endtask
endmodule // mad_host_model

// ---- sim/mmio_address_decoder_tb_top.sv ----
// self-checking bench for the mmio address decoder
`timescale 1ns/1ps
module mmio_address_decoder_tb_top;
   // ------------------------------------------------------------
   // cycle kinds {mem,write,wide} and decode flag masks
   // ------------------------------------------------------------
   localparam logic [2:0]  RD = 3'h4, WR = 3'h6, W32 = 3'h7, R32 = 3'h5;
   localparam logic [2:0]  IOR = 3'h0;
   localparam logic [9:0]  ALL = 10'h3ff, H = 10'h200, RF = 10'h100;
   localparam logic [9:0]  RZ = 10'h080, BE = 10'h040, PP = 10'h020;
   localparam logic [9:0]  IO = 10'h010, HRR = 10'h30f;
   localparam logic [31:0] B = 32'h14000000;
   logic                 clk, nrst, av_read, av_write, av_waitrequest;
   logic                 pci_strap_pin, hc_valid, dec_valid;
   logic                 legacy_enabled, new_enabled, io_access_allowed;
   logic [4:0]           av_address;
   logic [31:0]          av_writedata, av_readdata, rd;
   logic [3:0]           av_byteenable;
   logic [5:0]           pci_bar0_hi;
   mad_pkg::mad_cycle_t  hc_cycle;
   mad_pkg::mad_decode_t dec_result;
   int                   bad_count, tests_run, cyc;

   mad_decoder dut (.clk(clk), .nrst(nrst), .av_address(av_address),
      .av_read(av_read), .av_write(av_write), .av_writedata(av_writedata),
      .av_byteenable(av_byteenable), .av_readdata(av_readdata),
      .av_waitrequest(av_waitrequest), .pci_strap_pin(pci_strap_pin),
      .pci_bar0_hi(pci_bar0_hi), .hc_valid(hc_valid), .hc_cycle(hc_cycle),
      .dec_valid(dec_valid), .dec_result(dec_result),
      .legacy_enabled(legacy_enabled), .new_enabled(new_enabled),
      .io_access_allowed(io_access_allowed));
   mad_host_model host (.clk(clk), .hc_valid(hc_valid), .hc_cycle(hc_cycle));

   // ------------------------------------------------------------
   // clock, hang guard, shared tasks
   // ------------------------------------------------------------
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // the whole run needs under two hundred cycles; far more means a hang
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         bad_count++;
         wrap_up;
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         bad_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // avalon transfer held until waitrequest is seen low at an edge
   task automatic bus(input logic w, input logic [4:0] a,
                      input logic [31:0] d);
      av_address <= a;
      av_writedata <= d;
      av_read <= ~w;
      av_write <= w;
      do
         @(posedge clk);
      while (av_waitrequest !== 1'b0);
      rd = av_readdata;
      av_read <= 1'b0;
      av_write <= 1'b0;
      // enable outputs lag the registers by one edge; let it pass
      repeat (2) @(posedge clk);
   endtask
   // offer one host cycle and judge the masked decode one edge later
   task automatic dec(input logic [2:0] k, input logic [31:0] a,
                      input logic [9:0] e, input logic [9:0] m);
      mad_pkg::mad_decode_t r;
      host.offer({k, a});
      #1;
      r = dec_result;
      chk({dec_valid, m & {r.hit, r.refused, r.read_zero, r.big_endian,
         r.packed_pair, r.io_equiv, r.region}}, {1'b1, e & m});
      @(posedge clk);
   endtask
   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_reset_pci;
      bus(1'b0, mad_pkg::OFS_CONFIG, 32'h0);
      chk(rd[4:3], 2'h3);
      chk(new_enabled, 1'b1);
      chk(legacy_enabled, 1'b0);
      bus(1'b0, 5'h18, 32'h0);
      chk(rd, 32'h0);
      $display("test reset_pci done");
   endtask
   task automatic t_new_map;
      dec(RD, B + 32'h10, H | mad_pkg::RGN_LINEAR, ALL);
      dec(RD, B + 32'h2000010, H | BE | mad_pkg::RGN_LINEAR, ALL);
      dec(WR, B + 32'h3007ffe, H | BE | IO | mad_pkg::RGN_IMAGE, ALL);
      dec(RD, B + 32'h100803e, H | mad_pkg::RGN_PCI_CFG, ALL);
      dec(RD, B + 32'h10082ea, H | mad_pkg::RGN_CURRENT_Y_POSITION, ALL);
      dec(RD, B + 32'h1008502, H | mad_pkg::RGN_SYS_REG, ALL);
      dec(WR, B + 32'h100850c, H | mad_pkg::RGN_SYS_REG, ALL);
      dec(WR, B + 32'h100eeea, H | mad_pkg::RGN_ENH_REG, ALL);
      dec(WR, B + 32'h1013ffe, H | mad_pkg::RGN_PF_DATA, ALL);
      dec(WR, B + 32'h1014000, H | mad_pkg::RGN_PF_MASK, ALL);
      dec(RD, B + 32'h101809e, H | mad_pkg::RGN_PF_REG, ALL);
      dec(W32, B + 32'h1008100, H | PP | mad_pkg::RGN_PACKED, ALL);
      dec(R32, B + 32'h1008100, RF, RF);
      dec(RD, B + 32'h1008040, RZ, ALL);
      dec(WR, B + 32'h1008040, 10'h000, ALL);
      $display("test new_map done");
   endtask
   task automatic t_legacy;
      bus(1'b1, mad_pkg::OFS_CONFIG, 32'h10);
      chk({legacy_enabled, new_enabled}, 2'h2);
      dec(WR, 32'h000a7ffe, H | IO | mad_pkg::RGN_PIXEL_IO, ALL);
      dec(RD, 32'h000a82e8, H | mad_pkg::RGN_LEG_CMD, HRR);
      dec(W32, 32'h000a82e8, RF, RF);
      bus(1'b1, mad_pkg::OFS_MISC, 32'h200);
      dec(W32, 32'h000a82e8, H | mad_pkg::RGN_LEG_CMD, HRR);
      dec(R32, 32'h000a82e8, RF, RF);
      $display("test legacy done");
   endtask
   task automatic t_legacy_alt;
      bus(1'b1, mad_pkg::OFS_CONFIG, 32'h0);
      bus(1'b1, mad_pkg::OFS_AFC, 32'h20);
      chk({legacy_enabled, new_enabled}, 2'h2);
      bus(1'b1, mad_pkg::OFS_CONFIG, 32'h08);
      chk({legacy_enabled, new_enabled}, 2'h0);
      bus(1'b1, mad_pkg::OFS_AFC, 32'h0);
      $display("test legacy_alt done");
   endtask
   task automatic t_access_sel;
      bus(1'b1, mad_pkg::OFS_CONFIG, 32'h18);
      bus(1'b1, mad_pkg::OFS_SEQ, 32'h80);
      chk(io_access_allowed, 1'b0);
      dec(IOR, 32'h000082e8, 10'h000, H);
      bus(1'b1, mad_pkg::OFS_SEQ, 32'h0);
      chk(io_access_allowed, 1'b1);
      dec(IOR, 32'h000082e8, H, H);
      $display("test access_sel done");
   endtask
   // second reset with the strap low: base then comes from the register
   task automatic t_vl_base;
      nrst <= 1'b0;
      pci_strap_pin <= 1'b0;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      repeat (12) @(posedge clk);
      bus(1'b0, mad_pkg::OFS_CONFIG, 32'h0);
      chk(rd[4:3], 2'h0);
      chk(new_enabled, 1'b0);
      bus(1'b1, mad_pkg::OFS_WBASE, 32'h0c);
      bus(1'b1, mad_pkg::OFS_CONFIG, 32'h18);
      dec(RD, 32'h0c000010, H | mad_pkg::RGN_LINEAR, ALL);
      dec(RD, B + 32'h10, 10'h000, H);
      $display("test vl_base done");
   endtask

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial
   begin
      nrst = 1'b0;
      pci_strap_pin = 1'b1;
      pci_bar0_hi = 6'h05;
      av_address = 5'h00;
      av_read = 1'b0;
      av_write = 1'b0;
      av_writedata = 32'h0;
      av_byteenable = 4'hf;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      repeat (12) @(posedge clk);
      t_reset_pci;
      t_new_map;
      t_legacy;
      t_legacy_alt;
      t_access_sel;
      t_vl_base;
      wrap_up;
   end
endmodule // mmio_address_decoder_tb_top
